/* hw/stxe_exec.sv */
// stxe_exec: executes zero skips, bit skip, table reads and xor forms
// assumes decode gives one op pulse per cycle and memory read data is combinational
`timescale 1ns/1ps
// How it works
// - copy byte to acc, skip if zero
// - taken skip inserts one dummy cycle
// - bit skip when bit zero, flags untouched
// - current page table read, low/high split
// - final page table read at pointer offset
// - acc gets acc xor memory, zero flag
// - memory gets acc xor memory, acc kept
// - acc gets acc xor immediate, zero flag
module stxe_exec (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// decoded instruction
	input wire logic op_valid,
	input wire stxe_pkg::stxe_op_t op,
	input wire logic op_imm,
	input wire logic [stxe_pkg::DATA_W-1:0] imm_data,
	input wire logic [stxe_pkg::BIT_SEL_W-1:0] bit_sel,
	input wire logic [stxe_pkg::DATA_W-1:0] mem_rdata,
	// table context
	input wire logic [stxe_pkg::DATA_W-1:0] table_pointer_reg,
	input wire logic [stxe_pkg::PAGE_W-1:0] cur_page,
	input wire logic [stxe_pkg::PWORD_W-1:0] prog_word,
	// results
	output logic [stxe_pkg::PADDR_W-1:0] prog_addr,
	output logic [stxe_pkg::DATA_W-1:0] acc,
	output logic zero_flag,
	output logic mem_we,
	output logic [stxe_pkg::DATA_W-1:0] mem_wdata,
	output logic [5:0] table_high_byte_reg,
	output logic skip_next,
	output logic busy
);
	stxe_pkg::stxe_state_t state;
	stxe_prog_if prog ();
	logic tab_final;
	logic take;
	logic take_skip;
	logic take_tab;
	logic take_xor_mem;
	logic tab_cycle;
	logic skip_hit;
	logic byte_zero;
	logic bit_clear;
	logic is_tab;
	logic is_xor_acc;
	logic is_xor_mem;
	logic use_imm;
	logic xor_zero;
	logic [stxe_pkg::DATA_W-1:0] xor_src;
	logic [stxe_pkg::DATA_W-1:0] xor_res;
	logic [stxe_pkg::DATA_W-1:0] tab_low;
	logic [5:0] tab_high;

	// an op is taken only while no dummy or fetch cycle runs
	assign take = op_valid && (state == stxe_pkg::STXE_ST_IDLE);
	assign take_skip = take && skip_hit;
	assign take_tab = take && is_tab;
	assign take_xor_mem = take && is_xor_mem;
	assign tab_cycle = state == stxe_pkg::STXE_ST_TFETCH;

	// op decode
	assign is_tab = (op == stxe_pkg::STXE_OP_TAB_CUR) || (op == stxe_pkg::STXE_OP_TAB_FINAL);
	assign is_xor_acc = op == stxe_pkg::STXE_OP_XOR_ACC;
	assign is_xor_mem = op == stxe_pkg::STXE_OP_XOR_MEM;
	assign use_imm = op_imm && is_xor_acc;

	// page select follows the op, so the address is right at the take edge
	assign tab_final = op == stxe_pkg::STXE_OP_TAB_FINAL;

	// program word split
	assign prog.word = prog_word;
	assign tab_low = prog.word[7:0];
	assign tab_high = prog.word[13:8];

	stxe_tab_addr u_addr (
		.final_page(tab_final),
		.cur_page(cur_page),
		.tbl_ptr(table_pointer_reg),
		.prog(prog.core)
	);

	// zero tests on the addressed byte
	assign byte_zero = mem_rdata == stxe_pkg::ZERO_BYTE;
	assign bit_clear = !mem_rdata[bit_sel];

	// skip conditions
	always_comb begin
		case (op)
			stxe_pkg::STXE_OP_COPY_SKIP_ZERO: skip_hit = byte_zero;
			stxe_pkg::STXE_OP_SKIP_ZERO: skip_hit = byte_zero;
			stxe_pkg::STXE_OP_SKIP_BIT_ZERO: skip_hit = bit_clear;
			default: skip_hit = 1'h0;
		endcase
	end

	// xor operand and per-bit result
	assign xor_src = use_imm ? imm_data : mem_rdata;
	for (genvar b = 0; b < stxe_pkg::DATA_W; b++) begin : g_xor
		assign xor_res[b] = acc[b] ^ xor_src[b];
	end

	// zero test of the xor result
	assign xor_zero = xor_res == stxe_pkg::ZERO_BYTE;

	// sequencing: taken skip holds a dummy cycle, table read uses a fetch cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= stxe_pkg::STXE_ST_IDLE;
		end else begin
			case (state)
				stxe_pkg::STXE_ST_IDLE: begin
					if (take_skip) begin
						state <= stxe_pkg::STXE_ST_DUMMY;
					end else if (take_tab) begin
						state <= stxe_pkg::STXE_ST_TFETCH;
					end
				end
				stxe_pkg::STXE_ST_DUMMY: begin
					state <= stxe_pkg::STXE_ST_IDLE;
				end
				stxe_pkg::STXE_ST_TFETCH: begin
					state <= stxe_pkg::STXE_ST_IDLE;
				end
				default: begin
					state <= stxe_pkg::STXE_ST_IDLE;
				end
			endcase
		end
	end

	// busy covers the dummy cycle and the table fetch cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy <= 1'h0;
		end else if (take_skip || take_tab) begin
			busy <= 1'h1;
		end else begin
			busy <= 1'h0;
		end
	end

	// one-cycle mark that the next fetched instruction is dropped
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			skip_next <= 1'h0;
		end else begin
			skip_next <= take_skip;
		end
	end

	// table address latched at the take edge, stands through the fetch cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prog_addr <= '0;
		end else if (take_tab) begin
			prog_addr <= prog.addr;
		end
	end

	// accumulator
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acc <= stxe_pkg::ACC_RST;
		end else if (take) begin
			case (op)
				stxe_pkg::STXE_OP_COPY_SKIP_ZERO: begin
					acc <= mem_rdata;
				end
				stxe_pkg::STXE_OP_XOR_ACC: begin
					acc <= xor_res;
				end
				default: begin
					acc <= acc;
				end
			endcase
		end
	end

	// zero flag, only xor forms touch it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			zero_flag <= 1'h0;
		end else if (take && (is_xor_acc || is_xor_mem)) begin
			zero_flag <= xor_zero;
		end
	end

	// one-cycle data memory write strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mem_we <= 1'h0;
		end else begin
			mem_we <= take_xor_mem || tab_cycle;
		end
	end

	// data memory write value
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mem_wdata <= stxe_pkg::ZERO_BYTE;
		end else if (take_xor_mem) begin
			mem_wdata <= xor_res;
		end else if (tab_cycle) begin
			mem_wdata <= tab_low;
		end
	end

	// table high byte
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			table_high_byte_reg <= stxe_pkg::TABLE_HIGH_BYTE_REG_RST;
		end else if (tab_cycle) begin
			table_high_byte_reg <= tab_high;
		end
	end
endmodule : stxe_exec

/* hw/stxe_pkg.sv */
// stxe_pkg: constants and types for the skip, table-read and xor execute block
// assumes an 8-bit data path, 14-bit program words and 11-bit program addresses
package stxe_pkg;
	localparam int DATA_W = 8;
	localparam int PWORD_W = 14;
	localparam int PADDR_W = 11;
	localparam int PAGE_W = 3;
	localparam int BIT_SEL_W = 3;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [5:0] TABLE_HIGH_BYTE_REG_RST = 6'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [PAGE_W-1:0] FINAL_PAGE = 3'h7;
	typedef enum logic [2:0] {
		STXE_OP_NONE,
		STXE_OP_COPY_SKIP_ZERO,
		STXE_OP_SKIP_ZERO,
		STXE_OP_SKIP_BIT_ZERO,
		STXE_OP_TAB_CUR,
		STXE_OP_TAB_FINAL,
		STXE_OP_XOR_ACC,
		STXE_OP_XOR_MEM
	} stxe_op_t;
	typedef enum logic [1:0] {
		STXE_ST_IDLE,
		STXE_ST_DUMMY,
		STXE_ST_TFETCH
	} stxe_state_t;
endpackage : stxe_pkg

/* hw/stxe_prog_if.sv */
// stxe_prog_if: program memory read path used by the table reads
// assumes the program memory answers combinationally to the address
`timescale 1ns/1ps
interface stxe_prog_if;
	logic [stxe_pkg::PADDR_W-1:0] addr;
	logic [stxe_pkg::PWORD_W-1:0] word;
	modport core (output addr, input word);
	modport gen (input addr, output word);
endinterface : stxe_prog_if

/* hw/stxe_tab_addr.sv */
// stxe_tab_addr: forms the table address from page and pointer
// assumes pointer and page come from registers in the same clock domain
`timescale 1ns/1ps
module stxe_tab_addr (
	// select
	input wire logic final_page,
	input wire logic [stxe_pkg::PAGE_W-1:0] cur_page,
	input wire logic [stxe_pkg::DATA_W-1:0] tbl_ptr,
	// program path
	stxe_prog_if.core prog
);
	// current page or final page, pointer is the offset
	assign prog.addr = {final_page ? stxe_pkg::FINAL_PAGE : cur_page, tbl_ptr};
endmodule : stxe_tab_addr

/* testbench/stxe_exec_bench.sv */
// stxe_exec_bench: directed tests of stxe_exec
// assumes the checker binds itself
`timescale 1ns/1ps
module stxe_exec_bench;
	logic mclk = 1'h0, rst_n = 1'h0, op_valid = 1'h0, op_imm = 1'h0;
	logic zero_flag, mem_we, skip_next, busy;
	logic [7:0] imm_data = 8'h00, mem_rdata = 8'h00, table_pointer_reg = 8'hA5, acc, mem_wdata;
	logic [2:0] bit_sel = 3'h3, cur_page = 3'h2;
	logic [10:0] prog_addr;
	wire [13:0] prog_word = {3'h5, prog_addr};
	logic [5:0] table_high_byte_reg;
	stxe_pkg::stxe_op_t op = stxe_pkg::STXE_OP_NONE;
	int err_total = 0, n_checks = 0;
	always #20 mclk = ~mclk;
	stxe_exec stxe_exec_i (
		.mclk(mclk),
		.rst_n(rst_n),
		.op_valid(op_valid),
		.op(op),
		.op_imm(op_imm),
		.imm_data(imm_data),
		.bit_sel(bit_sel),
		.mem_rdata(mem_rdata),
		.table_pointer_reg(table_pointer_reg),
		.cur_page(cur_page),
		.prog_word(prog_word),
		.prog_addr(prog_addr),
		.acc(acc),
		.zero_flag(zero_flag),
		.mem_we(mem_we),
		.mem_wdata(mem_wdata),
		.table_high_byte_reg(table_high_byte_reg),
		.skip_next(skip_next),
		.busy(busy)
	);
	task chk(input logic [16:0] g, e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h", $time, g);
		end
	endtask : chk
	task go(input logic [2:0] o, input logic [16:0] v);
		@(posedge mclk);
		op_valid <= 1'h1;
		op <= stxe_pkg::stxe_op_t'(o);
		{op_imm, imm_data, mem_rdata} <= v;
		@(posedge mclk);
		op_valid <= 1'h0;
		#1;
	endtask : go
	task t_alu;
		go(3'h1, 17'h00000);
		chk({acc, skip_next, busy}, 17'h003);
		go(3'h6, 17'h0003C);
		chk({acc, zero_flag}, 17'h078);
		go(3'h7, 17'h0000F);
		chk({mem_we, mem_wdata, acc}, 17'h1333C);
		go(3'h6, 17'h13CFF);
		chk({acc, zero_flag}, 17'h001);
		go(3'h3, 17'h000F7);
		chk({skip_next, zero_flag}, 17'h003);
		$display("alu test done");
	endtask : t_alu
	task t_skip;
		go(3'h2, 17'h00000);
		chk({skip_next, busy}, 17'h003);
		go(3'h2, 17'h00001);
		chk({skip_next, busy}, 17'h000);
		go(3'h3, 17'h00008);
		chk({skip_next, zero_flag}, 17'h001);
		go(3'h1, 17'h00042);
		chk({acc, skip_next, busy}, 17'h108);
		@(posedge mclk);
		op_valid <= 1'h1;
		op <= stxe_pkg::STXE_OP_SKIP_ZERO;
		mem_rdata <= 8'h00;
		@(posedge mclk);
		op <= stxe_pkg::STXE_OP_XOR_ACC;
		mem_rdata <= 8'hFF;
		@(posedge mclk);
		op_valid <= 1'h0;
		#1;
		chk({acc, skip_next, busy}, 17'h108);
		$display("skip test done");
	endtask : t_skip
	task t_tab;
		go(3'h4, 17'h00000);
		chk(prog_addr, 17'h2A5);
		@(posedge mclk);
		#1;
		chk({mem_we, mem_wdata, table_high_byte_reg}, 17'h696A);
		go(3'h5, 17'h00000);
		chk({table_high_byte_reg, prog_addr}, 17'h157A5);
		@(posedge mclk);
		#1;
		chk({mem_we, mem_wdata, table_high_byte_reg}, 17'h696F);
		$display("table test done");
	endtask : t_tab
	task finish_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		t_alu;
		t_skip;
		t_tab;
		finish_test;
	end
endmodule : stxe_exec_bench

/* testbench/stxe_exec_sva.sv */
// stxe_exec_sva: port assertions for stxe_exec
// assumes op codes in stxe_pkg order
`timescale 1ns/1ps
module stxe_exec_sva (
	// watched ports
	input wire logic mclk, rst_n, op_valid, zero_flag, mem_we, skip_next, busy, op_imm,
	input wire stxe_pkg::stxe_op_t op,
	input wire logic [7:0] mem_rdata, acc, mem_wdata, imm_data,
	input wire logic [10:0] prog_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire tk = op_valid & ~busy;
	wire xm = tk && op == 3'h7;
	chk_copy_acc: assert property (tk && op == 3'h1 |=> acc == $past(mem_rdata))
		else $error("copy");
	chk_skip_dummy: assert property (tk && op inside {3'h1, 3'h2} && mem_rdata == 8'h00
		|=> skip_next && busy ##1 !busy) else $error("skip");
	chk_flags_kept: assert property (tk && op == 3'h3 |=> $stable(zero_flag)) else $error("flag");
	chk_tab_write: assert property (tk && op[2:1] == 2'h2
		|=> busy ##1 mem_we && !busy) else $error("table");
	chk_xm_data: assert property (xm |=> mem_wdata == ($past(acc) ^ $past(mem_rdata)))
		else $error("xor");
	chk_xm_acc: assert property (xm |=> mem_we && $stable(acc)) else $error("acc");
	chk_xm_zero: assert property (xm |=> zero_flag == (mem_wdata == 8'h00)) else $error("z");
	chk_xa_zero: assert property (tk && op == 3'h6 |=> zero_flag == (acc == 8'h00))
		else $error("zero");
	chk_xa_value: assert property (tk && op == 3'h6 |=> acc ==
		($past(acc) ^ ($past(op_imm) ? $past(imm_data) : $past(mem_rdata)))) else $error("xacc");
	chk_tab_page: assert property (tk && op == 3'h5 |=> prog_addr[10:8] == 3'h7)
		else $error("page");
	cover property (skip_next);
	cover property (mem_we);
	cover property (busy);
endmodule : stxe_exec_sva
bind stxe_exec stxe_exec_sva stxe_exec_sva_i (.*);
